// File: line_output_source_assertions.sv
// Checker: port-level assertions for the line output source mux
`timescale 1ns/1ps

module line_output_source_assertions (
  input wire logic                                         sys_clk,
  input wire logic                                         resetn,
  input wire line_output_source_pkg::reg_req_t             regReq,
  input wire logic [31:0]                                  regRdata,
  input wire logic [line_output_source_pkg::NUM_LINES-1:0] lineOe_n,
  input wire logic [line_output_source_pkg::NUM_LINES-1:0] lineHighZ,
  input wire logic                                         irq
);
  import line_output_source_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Sequences
  sequence userBitWrite;
    regReq.wr && regReq.addr == REG_USER_BIT;
  endsequence

  sequence userBitRead;
    regReq.rd && regReq.addr == REG_USER_BIT;
  endsequence

  // ==========================================================
  // Register port
  chk_user_readback : assert property (
    userBitWrite ##1 userBitRead |=> regRdata[0] == $past(regReq.wdata[0], 2))
    else $error("single user bit did not read back as written");

  chk_rdata_idle : assert property (
    !$past(regReq.rd) |-> regRdata == 32'h0)
    else $error("read data present without a read");

  chk_unmapped_read : assert property (
    regReq.rd && regReq.addr > REG_LINE_STATUS |=> regRdata == 32'h0)
    else $error("unmapped read returned data");

  // ==========================================================
  // Line drivers
  chk_highz_nodrive : assert property (
    (~lineOe_n & lineHighZ) == '0)
    else $error("line driven while marked high impedance");

  chk_reset_input : assert property (
    $rose(resetn) |-> &lineOe_n && &lineHighZ)
    else $error("line not released after reset");

  // Only a write one or two cycles earlier may move a driver enable
  chk_drive_cause : assert property (
    !$stable(lineOe_n) |-> $past(regReq.wr) || $past(regReq.wr, 2))
    else $error("driver enable moved without a write");

  // ==========================================================
  // Interrupt
  chk_irq_fall : assert property (
    $fell(irq) |-> $past(regReq.wr))
    else $error("interrupt dropped without a write");

  chk_irq_masked : assert property (
    regReq.wr && regReq.addr == REG_IRQ_MASK && regReq.wdata[5:0] == 6'h00 |=> !irq)
    else $error("interrupt high with all sources masked");

endmodule : line_output_source_assertions

bind line_output_source_mux line_output_source_assertions chk (
  .sys_clk, .resetn, .regReq, .regRdata, .lineOe_n, .lineHighZ, .irq
);

// File: line_output_source_mux.sv
// Line output source mux with user output bits, counters/timers and interrupts
`timescale 1ns/1ps

module line_output_source_mux (
  input  wire logic                                          sys_clk,
  input  wire logic                                          resetn,
  input  wire line_output_source_pkg::reg_req_t              regReq,
  output logic [31:0]                                        regRdata,
  input  wire line_output_source_pkg::acq_status_t           acqStatus,
  input  wire logic [line_output_source_pkg::NUM_STREAMS*5-1:0] streamState,
  input  wire logic [line_output_source_pkg::NUM_COUNTERS-1:0]  internalEvent,
  input  wire logic [line_output_source_pkg::NUM_LINES-1:0]     lineIn,
  output logic [line_output_source_pkg::NUM_LINES-1:0]          lineOut,
  output logic [line_output_source_pkg::NUM_LINES-1:0]          lineOe_n,
  output logic [line_output_source_pkg::NUM_LINES-1:0]          lineHighZ,
  output logic                                               irq
);
  import line_output_source_pkg::*;

  localparam int NUM_UNITS = NUM_COUNTERS + NUM_TIMERS;

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [USER_BITS-1:0] bitMask(input logic [2:0] idx);
    bitMask = USER_BITS'(1) << idx;
  endfunction : bitMask

  // ==========================================================
  // Storage
  logic [1:0]               lineIndex;
  line_cfg_t                lineCfg [NUM_LINES];
  logic [2:0]               userIndex;
  logic [USER_BITS-1:0]     userBits;
  logic [USER_BITS-1:0]     userMask;
  logic [2:0]               unitIndex;
  unit_cfg_t                unitCfg [NUM_UNITS];
  logic [CNT_W-1:0]         unitValue [NUM_UNITS];
  logic [CNT_W-1:0]         unitMax [NUM_UNITS];
  unit_state_t              unitState [NUM_UNITS];
  logic [NUM_UNITS-1:0]     unitEnd;
  logic [NUM_UNITS-1:0]     unitActive;
  logic [NUM_UNITS-1:0]     irqStatus;
  logic [NUM_UNITS-1:0]     irqMask;
  logic [NUM_LINES-1:0]     linePrev;
  logic [NUM_LINES-1:0]     lineEdge;
  logic [NUM_LINES-1:0]     lineLevel;
  logic                     edgeArmed;

  logic wrEn;
  logic rdEn;
  assign wrEn = regReq.wr;
  assign rdEn = regReq.rd;

  // ==========================================================
  // Selectors
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lineIndex <= 2'h0;
      userIndex <= 3'h0;
      unitIndex <= 3'h0;
    end else if (wrEn) begin
      if (hit(regReq.addr, REG_LINE_INDEX)) begin
        lineIndex <= regReq.wdata[1:0];
      end
      if (hit(regReq.addr, REG_USER_INDEX)) begin
        userIndex <= regReq.wdata[2:0];
      end
      // Indices past the last unit are dropped so no access reaches past the arrays
      if (hit(regReq.addr, REG_CNT_INDEX) && regReq.wdata[2:0] < 3'(NUM_UNITS)) begin
        unitIndex <= regReq.wdata[2:0];
      end
    end
  end

  // ==========================================================
  // Per-line configuration
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        lineCfg[i] <= '{src: SRC_OFF, dirOut: 1'b0, invert: 1'b0, fmt: FMT_TTL};
      end
    end else if (wrEn && hit(regReq.addr, REG_LINE_CFG)) begin
      lineCfg[lineIndex].src    <= source_t'(regReq.wdata[LCFG_SRC_LSB +: 5]);
      lineCfg[lineIndex].dirOut <= regReq.wdata[LCFG_DIR_BIT];
      lineCfg[lineIndex].invert <= regReq.wdata[LCFG_INV_BIT];
      // Code 7 is refused; the other fields of the same write still land
      if (regReq.wdata[LCFG_FMT_LSB +: 3] <= FMT_OPENDRAIN) begin
        lineCfg[lineIndex].fmt <= format_t'(regReq.wdata[LCFG_FMT_LSB +: 3]);
      end
    end
  end

  // ==========================================================
  // User output register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      userBits <= USER_RESET;
      userMask <= MASK_RESET;
    end else if (wrEn) begin
      if (hit(regReq.addr, REG_USER_BIT)) begin
        // Mask deliberately not applied here
        if (regReq.wdata[0]) begin
          userBits <= userBits | bitMask(userIndex);
        end else begin
          userBits <= userBits & ~bitMask(userIndex);
        end
      end
      if (hit(regReq.addr, REG_USER_BULK)) begin
        userBits <= (regReq.wdata[USER_BITS-1:0] & userMask)
                  | (userBits & ~userMask);
      end
      if (hit(regReq.addr, REG_USER_MASK)) begin
        userMask <= regReq.wdata[USER_BITS-1:0];
      end
    end
  end

  // ==========================================================
  // Input edge detection for counters fed from lines
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      linePrev <= '0;
    end else begin
      linePrev <= lineLevel;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      lineLevel[i] = lineIn[i] ^ lineCfg[i].invert;
    end
  end
  // Edges are ignored until one cycle after reset, so a line that is already
  // high when reset lifts is not taken for a fresh edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      edgeArmed <= 1'b0;
    end else begin
      edgeArmed <= 1'b1;
    end
  end
  assign lineEdge = lineLevel & ~linePrev & {NUM_LINES{edgeArmed}};

  // ==========================================================
  // Counters (units 0..2) and timers (units 3..5)
  // Timers share the counter engine; every unit resets to the clock tick as its event
  logic [NUM_UNITS-1:0] unitInc;
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      // Chaining wins over the unit's own event source on every unit but unit 0
      if (unitCfg[u].chain && u > 0) begin
        unitInc[u] = unitEnd[(u > 0) ? u - 1 : 0];
      end else begin
        case (unitCfg[u].evt)
          EVT_INTERNAL: unitInc[u] = internalEvent[u % NUM_COUNTERS];
          EVT_LINE:     unitInc[u] = lineEdge[unitCfg[u].lineSel];
          EVT_TICK:     unitInc[u] = 1'b1;
          default:      unitInc[u] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        unitCfg[u] <= '{evt: EVT_TICK, chain: 1'b0, enable: 1'b0, lineSel: 2'h0};
        unitMax[u] <= MAX_RESET;
      end
    end else if (wrEn) begin
      if (hit(regReq.addr, REG_CNT_CFG)) begin
        unitCfg[unitIndex].evt     <= count_event_t'(regReq.wdata[CCFG_EVT_LSB +: 2]);
        unitCfg[unitIndex].chain   <= regReq.wdata[CCFG_CHAIN_BIT];
        unitCfg[unitIndex].enable  <= regReq.wdata[CCFG_ENABLE_BIT];
        unitCfg[unitIndex].lineSel <= regReq.wdata[CCFG_LINE_LSB +: 2];
      end
      if (hit(regReq.addr, REG_CNT_MAX)) begin
        unitMax[unitIndex] <= regReq.wdata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        unitValue[u] <= '0;
        unitState[u] <= UNIT_IDLE;
      end
      unitEnd <= '0;
    end else begin
      unitEnd <= '0;
      for (int u = 0; u < NUM_UNITS; u++) begin
        // A disabled unit keeps its value; only software clears it
        case (unitState[u])
          UNIT_IDLE: begin
            if (unitCfg[u].enable) begin
              unitState[u] <= UNIT_COUNT;
            end
          end
          UNIT_COUNT: begin
            if (!unitCfg[u].enable) begin
              unitState[u] <= UNIT_IDLE;
            end else if (unitInc[u]) begin
              if (unitValue[u] >= unitMax[u]) begin
                unitValue[u] <= '0;
                unitEnd[u]   <= 1'b1;
              end else begin
                unitValue[u] <= unitValue[u] + 1'b1;
              end
            end
          end
          default: unitState[u] <= UNIT_IDLE;
        endcase
      end
      // Software reset or write of the value wins over counting
      if (wrEn && hit(regReq.addr, REG_CNT_CMD) && regReq.wdata[CCMD_RESET_BIT]) begin
        unitValue[unitIndex] <= '0;
      end
      if (wrEn && hit(regReq.addr, REG_CNT_VALUE)) begin
        unitValue[unitIndex] <= regReq.wdata[CNT_W-1:0];
      end
    end
  end

  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      unitActive[u] = (unitState[u] == UNIT_COUNT);
    end
  end

  // ==========================================================
  // Interrupts: end events, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus <= '0;
      irqMask   <= '0;
    end else begin
      if (wrEn && hit(regReq.addr, REG_IRQ_STATUS)) begin
        irqStatus <= (irqStatus & ~regReq.wdata[NUM_UNITS-1:0]) | unitEnd;
      end else begin
        irqStatus <= irqStatus | unitEnd;
      end
      if (wrEn && hit(regReq.addr, REG_IRQ_MASK)) begin
        irqMask <= regReq.wdata[NUM_UNITS-1:0];
      end
    end
  end
  // The mask gates only the output; status keeps recording end events
  assign irq = |(irqStatus & irqMask);

  // ==========================================================
  // Source selection
  // Codes past the last stream state give a low level, never a guess
  function automatic logic pickSource(input source_t s);
    logic [4:0] code;
    logic [4:0] rel;
    code = s;
    rel  = 5'h00;
    pickSource = 1'b0;
    case (1'b1)
      (code == SRC_ACQ_WAIT):   pickSource = acqStatus.acqWaiting;
      (code == SRC_ACQ_ACTIVE): pickSource = acqStatus.acqInProgress;
      (code == SRC_FRAME_WAIT): pickSource = acqStatus.frameWaiting;
      (code == SRC_FRAME_ACT):  pickSource = acqStatus.frameInProgress;
      (code == SRC_EXPOSURE):   pickSource = acqStatus.exposureInProgress;
      (code >= SRC_COUNTER0 && code < SRC_TIMER0): begin
        rel = code - SRC_COUNTER0;
        pickSource = unitActive[rel[2:0]];
      end
      (code >= SRC_TIMER0 && code < SRC_USER0): begin
        rel = code - SRC_TIMER0;
        pickSource = unitActive[3'(NUM_COUNTERS) + rel[2:0]];
      end
      (code >= SRC_USER0 && code < SRC_STREAM0): begin
        rel = code - SRC_USER0;
        pickSource = userBits[rel[2:0]];
      end
      (code >= SRC_STREAM0 && code < 5'(SRC_STREAM0 + NUM_STREAMS * 5)): begin
        rel = code - SRC_STREAM0;
        pickSource = streamState[rel[3:0]];
      end
      default: pickSource = 1'b0;
    endcase
  endfunction : pickSource

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lineOut   <= '0;
      lineOe_n  <= '1;
      lineHighZ <= '1;
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        lineOut[i] <= pickSource(lineCfg[i].src) ^ lineCfg[i].invert;
        // Only a line set to output with a live source and a driven format drives
        lineOe_n[i] <= !(lineCfg[i].dirOut && lineCfg[i].src != SRC_OFF
                         && lineCfg[i].fmt != FMT_HIGHZ
                         && lineCfg[i].fmt != FMT_NOCONNECT);
        lineHighZ[i] <= (lineCfg[i].src == SRC_OFF) || !lineCfg[i].dirOut;
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  // Zero outside the answer cycle, so a stale word is never taken for a read
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (regReq.addr)
      REG_LINE_INDEX: next_rdata = {30'h0, lineIndex};
      REG_LINE_CFG: begin
        next_rdata[LCFG_SRC_LSB +: 5] = lineCfg[lineIndex].src;
        next_rdata[LCFG_DIR_BIT]      = lineCfg[lineIndex].dirOut;
        next_rdata[LCFG_INV_BIT]      = lineCfg[lineIndex].invert;
        next_rdata[LCFG_FMT_LSB +: 3] = lineCfg[lineIndex].fmt;
      end
      REG_USER_INDEX: next_rdata = {29'h0, userIndex};
      REG_USER_BIT:   next_rdata = {31'h0, userBits[userIndex]};
      REG_USER_BULK:  next_rdata = {24'h0, userBits};
      REG_USER_MASK:  next_rdata = {24'h0, userMask};
      REG_CNT_INDEX:  next_rdata = {29'h0, unitIndex};
      REG_CNT_CFG: begin
        next_rdata[CCFG_EVT_LSB +: 2]  = unitCfg[unitIndex].evt;
        next_rdata[CCFG_CHAIN_BIT]     = unitCfg[unitIndex].chain;
        next_rdata[CCFG_ENABLE_BIT]    = unitCfg[unitIndex].enable;
        next_rdata[CCFG_LINE_LSB +: 2] = unitCfg[unitIndex].lineSel;
      end
      REG_CNT_VALUE:   next_rdata = {16'h0, unitValue[unitIndex]};
      REG_CNT_MAX:     next_rdata = {16'h0, unitMax[unitIndex]};
      REG_IRQ_STATUS:  next_rdata = {26'h0, irqStatus};
      REG_IRQ_MASK:    next_rdata = {26'h0, irqMask};
      REG_LINE_STATUS: next_rdata = {28'h0, lineLevel};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (rdEn) begin
      regRdata <= next_rdata;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule : line_output_source_mux

// File: line_output_source_pkg.sv
// Package: constants, register map and types for the line output source mux
package line_output_source_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_LINES    = 4;
  localparam int NUM_COUNTERS = 3;
  localparam int NUM_TIMERS   = 3;
  localparam int NUM_STREAMS  = 2;
  localparam int USER_BITS    = 8;
  localparam int CNT_W        = 16;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_LINE_INDEX   = 8'h00;
  localparam logic [7:0] REG_LINE_CFG     = 8'h04;
  localparam logic [7:0] REG_USER_INDEX   = 8'h08;
  localparam logic [7:0] REG_USER_BIT     = 8'h0c;
  localparam logic [7:0] REG_USER_BULK    = 8'h10;
  localparam logic [7:0] REG_USER_MASK    = 8'h14;
  localparam logic [7:0] REG_CNT_INDEX    = 8'h18;
  localparam logic [7:0] REG_CNT_CFG      = 8'h1c;
  localparam logic [7:0] REG_CNT_VALUE    = 8'h20;
  localparam logic [7:0] REG_CNT_MAX      = 8'h24;
  localparam logic [7:0] REG_CNT_CMD      = 8'h28;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h2c;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h30;
  localparam logic [7:0] REG_LINE_STATUS  = 8'h34;

  // ==========================================================
  // Field positions of the line configuration word
  localparam int LCFG_SRC_LSB    = 0;   // 5-bit source code
  localparam int LCFG_DIR_BIT    = 8;   // 1 = output
  localparam int LCFG_INV_BIT    = 9;
  localparam int LCFG_FMT_LSB    = 12;  // 3-bit electrical format
  // Counter configuration word
  localparam int CCFG_EVT_LSB    = 0;   // 2-bit event kind
  localparam int CCFG_CHAIN_BIT  = 4;   // take increment from previous unit's end
  localparam int CCFG_ENABLE_BIT = 8;
  localparam int CCFG_LINE_LSB   = 12;  // 2-bit input line index
  // Counter command bits
  localparam int CCMD_RESET_BIT  = 0;

  // ==========================================================
  // Reset values
  localparam logic [USER_BITS-1:0] USER_RESET = 8'h00;
  localparam logic [USER_BITS-1:0] MASK_RESET = 8'hff;
  localparam logic [CNT_W-1:0]     MAX_RESET  = 16'hffff;

  // ==========================================================
  // Output source codes
  typedef enum logic [4:0] {
    SRC_OFF         = 5'h00,
    SRC_ACQ_WAIT    = 5'h01,
    SRC_ACQ_ACTIVE  = 5'h02,
    SRC_FRAME_WAIT  = 5'h03,
    SRC_FRAME_ACT   = 5'h04,
    SRC_EXPOSURE    = 5'h05,
    SRC_COUNTER0    = 5'h06,  // +n, n < 3
    SRC_TIMER0      = 5'h09,  // +n, n < 3
    SRC_USER0       = 5'h0c,  // +n, n < 8
    SRC_STREAM0     = 5'h14   // +5*stream + state, 10 codes
  } source_t;

  typedef enum logic [2:0] {
    STRM_ACTIVE   = 3'h0,
    STRM_PAUSED   = 3'h1,
    STRM_STOPPING = 3'h2,
    STRM_STOPPED  = 3'h3,
    STRM_OVERFLOW = 3'h4
  } stream_state_t;

  typedef enum logic [2:0] {
    FMT_NOCONNECT = 3'h0,
    FMT_HIGHZ     = 3'h1,
    FMT_TTL       = 3'h2,
    FMT_LVDS      = 3'h3,
    FMT_RS422     = 3'h4,
    FMT_OPTO      = 3'h5,
    FMT_OPENDRAIN = 3'h6
  } format_t;

  typedef enum logic [1:0] {
    EVT_INTERNAL = 2'h0,
    EVT_LINE     = 2'h1,
    EVT_TICK     = 2'h2
  } count_event_t;

  typedef enum logic [1:0] {
    UNIT_IDLE  = 2'b01,
    UNIT_COUNT = 2'b10
  } unit_state_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic acqWaiting;
    logic acqInProgress;
    logic frameWaiting;
    logic frameInProgress;
    logic exposureInProgress;
  } acq_status_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    source_t src;
    logic    dirOut;
    logic    invert;
    format_t fmt;
  } line_cfg_t;

  typedef struct packed {
    count_event_t evt;
    logic         chain;
    logic         enable;
    logic [1:0]   lineSel;
  } unit_cfg_t;

endpackage : line_output_source_pkg

// File: line_partner.sv
// Partner model: external equipment wired to the I/O lines
`timescale 1ns/1ps

module line_partner #(
  parameter int N = 4
) (
  input  wire logic         sys_clk,
  input  wire logic [N-1:0] lineOut,
  input  wire logic [N-1:0] lineOe_n,
  input  wire logic [N-1:0] extEn,
  input  wire logic [N-1:0] extLevel,
  output logic      [N-1:0] lineIn
);
  logic [N-1:0] lastLevel = '0;

  // Equipment backs off while the device drives, so no contention is modelled
  // A floating line shows the inverse of its last level, never a lucky match
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!lineOe_n[i]) lineIn[i] = lineOut[i];
      else if (extEn[i]) lineIn[i] = extLevel[i];
      else lineIn[i] = ~lastLevel[i];
    end
  end

  // Only driven levels are remembered, so a released line holds steady
  always @(posedge sys_clk) begin
    for (int i = 0; i < N; i++) begin
      if (!lineOe_n[i] || extEn[i]) lastLevel[i] <= lineIn[i];
    end
  end

endmodule : line_partner

// File: testbench.sv
// Testbench: self-checking bench for the line output source mux
`timescale 1ns/1ps

module testbench;
  import line_output_source_pkg::*;

  logic                     sys_clk       = 1'b0;
  logic                     resetn        = 1'b0;
  reg_req_t                 regReq        = '0;
  acq_status_t              acqStatus     = '0;
  logic [NUM_STREAMS*5-1:0] streamState   = '0;
  logic [NUM_COUNTERS-1:0]  internalEvent = '0;
  logic [NUM_LINES-1:0]     extEn         = '0;
  logic [NUM_LINES-1:0]     extLevel      = '0;
  logic [NUM_LINES-1:0]     invMask       = '0;
  logic [NUM_LINES-1:0]     lineIn, lineOut, lineOe_n, lineHighZ;
  logic [31:0]              regRdata, rv;
  logic                     irq;
  logic [7:0]               ubits         = 8'h00;
  logic [5:0]               unitOn        = '0;
  int                       mismatches    = 0;
  int                       compares      = 0;
  int                       m, v, b, x, inv, fmt;

  always #50 sys_clk = ~sys_clk;

  line_output_source_mux uut (
    .sys_clk, .resetn, .regReq, .regRdata, .acqStatus, .streamState, .internalEvent,
    .lineIn, .lineOut, .lineOe_n, .lineHighZ, .irq
  );

  line_partner #(.N(NUM_LINES)) partner (
    .sys_clk, .lineOut, .lineOe_n, .extEn, .extLevel, .lineIn
  );

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Kind 1 write, 2 read, 3 write then read at the same address back to back
  task automatic acc(input logic [7:0] a, input logic [31:0] d, input int k);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: k != 2, rd: k == 2};
    if (k == 3) begin
      @(posedge sys_clk);
      regReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
    end
    @(posedge sys_clk);
    regReq <= '0;
    #1 rv = regRdata;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(a, d, 1);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    acc(a, 32'h0, 2);
    chk(rv, exp);
  endtask : rdchk

  function automatic logic srcval(input int s);
    if (s >= 1 && s <= 5) return acqStatus[5-s];
    if (s >= 6 && s <= 11) return unitOn[s-6];
    if (s >= 12 && s <= 19) return ubits[s-12];
    if (s >= 20 && s <= 29) return streamState[s-20];
    return 1'b0;
  endfunction : srcval

  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h8a91));
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    chk(lineOe_n, 4'hf);
    rdchk(REG_USER_BULK, 32'h00);
    rdchk(REG_USER_MASK, 32'hff);
    rdchk(REG_LINE_CFG, 32'h2000);
    rdchk(8'h3c, 32'h0);
    $display("test reset finished");

    for (int i = 0; i < 12; i++) begin
      m = (i == 0) ? 0 : $urandom_range(255);
      v = $urandom_range(255);
      wr(REG_USER_MASK, m);
      wr(REG_USER_BULK, v);
      ubits = (ubits & ~m[7:0]) | (v[7:0] & m[7:0]);
      rdchk(REG_USER_BULK, ubits);
      b = $urandom_range(7);
      x = $urandom_range(1);
      wr(REG_USER_INDEX, b);
      acc(REG_USER_BIT, x, 3);
      ubits[b] = x[0];
      chk(rv, x);
      rdchk(REG_USER_BULK, ubits);
    end
    $display("test user bits finished");

    // Unit 0 counts internal pulses and feeds chained unit 1
    wr(REG_CNT_INDEX, 1);
    wr(REG_CNT_CFG, 32'h110);
    wr(REG_CNT_INDEX, 0);
    wr(REG_CNT_MAX, 2);
    wr(REG_CNT_CFG, 32'h100);
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      internalEvent <= 3'h1;
      @(posedge sys_clk);
      internalEvent <= 3'h0;
    end
    repeat (4) @(posedge sys_clk);
    wr(REG_CNT_CFG, 32'h0);
    rdchk(REG_CNT_VALUE, 1);
    rdchk(REG_IRQ_STATUS, 1);
    chk(irq, 1'b0);
    wr(REG_CNT_INDEX, 1);
    rdchk(REG_CNT_VALUE, 2);
    wr(REG_CNT_VALUE, 5);
    rdchk(REG_CNT_VALUE, 5);
    wr(REG_CNT_CMD, 1);
    rdchk(REG_CNT_VALUE, 0);
    wr(REG_IRQ_MASK, 1);
    chk(irq, 1'b1);
    wr(REG_IRQ_STATUS, 1);
    chk(irq, 1'b0);
    wr(REG_CNT_INDEX, 3);
    wr(REG_CNT_CFG, 32'h102);
    unitOn = 6'b001010;
    $display("test counters finished");

    // Every source code on every line, with an unknown code at the end
    for (int l = 0; l < NUM_LINES; l++) begin
      wr(REG_LINE_INDEX, l);
      for (int s = 0; s < 31; s++) begin
        inv = $urandom_range(1);
        @(posedge sys_clk);
        acqStatus <= 5'($urandom);
        streamState <= 10'($urandom);
        wr(REG_LINE_CFG, s | 32'h2100 | inv << 9);
        repeat (2) @(posedge sys_clk);
        #1 chk(lineOe_n[l], s == 0);
        chk(lineHighZ[l], s == 0);
        if (s != 0) chk(lineOut[l], srcval(s) ^ inv[0]);
      end
    end
    $display("test sources finished");

    wr(REG_LINE_INDEX, 0);
    for (int f = 0; f < 8; f++) begin
      wr(REG_LINE_CFG, 32'h10c | f << 12);
      if (f < 7) fmt = f;
      rdchk(REG_LINE_CFG, 32'h10c | fmt << 12);
      chk(lineOe_n[0], fmt < 2);
    end
    $display("test formats finished");

    @(posedge sys_clk);
    extEn <= 4'hf;
    extLevel <= 4'($urandom);
    invMask <= 4'($urandom);
    for (int l = 0; l < NUM_LINES; l++) begin
      wr(REG_LINE_INDEX, l);
      wr(REG_LINE_CFG, 32'h200c | {22'h0, invMask[l], 9'h0});
    end
    repeat (2) @(posedge sys_clk);
    #1 chk(lineOe_n, 4'hf);
    chk(lineHighZ, 4'hf);
    rdchk(REG_LINE_STATUS, extLevel ^ invMask);
    wr(REG_IRQ_MASK, 0);
    $display("test inputs finished");

    // Counter 2 counts rising edges of line 0 after its inverter
    @(posedge sys_clk);
    extLevel[0] <= invMask[0];
    wr(REG_CNT_INDEX, 2);
    wr(REG_CNT_CFG, 32'h101);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      extLevel[0] <= ~invMask[0];
      @(posedge sys_clk);
      extLevel[0] <= invMask[0];
    end
    rdchk(REG_CNT_VALUE, 3);
    $display("test line edges finished");
    end_sim();
  end

endmodule : testbench
